// ===== secreg_lock_map.svh
// offsets, opcodes, field positions, reset values and timing figures
// for the security register and block lock command handler
// assumes inclusion by bare name from the design files
`ifndef SECREG_LOCK_MAP_SVH
`define SECREG_LOCK_MAP_SVH

// serial opcodes
`define OP_SECREG_ERASE     8'h44
`define OP_SECREG_PROGRAM   8'h42
`define OP_SECREG_READ      8'h48
`define OP_BLOCK_LOCK       8'h36
`define OP_BLOCK_UNLOCK     8'h39
`define OP_BLOCK_LOCK_READ  8'h3D

// address decode of a security register address
`define SECREG_HI_BYTE      8'h00
`define SECREG_MID_NIBBLE   4'h0
`define SECREG_SEL_FIRST    4'h1
`define SECREG_SEL_LAST     4'h3

// bit counts on the link
`define CNT_ADDR_DONE       6'h20
`define CNT_ADDR_LAST       6'h1F
`define CNT_DUMMY_DONE      6'h28
`define CNT_READ_WRAP       6'h2F
`define CNT_BYTE_WRAP       6'h27

// memory shape
`define SECREG_COUNT        3
`define SECREG_ADDR_W       10
`define SECREG_DATA_W       8
`define ERASED_BYTE         8'hFF
`define LAST_OFFSET         8'hFF
`define LOCK_COUNT          256
`define LOCK_RESET          1'h1

// fifo in the program data path
`define PROG_FIFO_DEPTH     8

// timing
`define CLK_MHZ             125
`define SECTOR_ERASE_TIME_US 400

`endif

// ===== secreg_lock_pkg.sv
// types for the security register and block lock command handler
// assumes secreg_lock_map.svh is reachable by bare name
`include "secreg_lock_map.svh"

package secreg_lock_pkg;

	typedef enum logic [2:0] {
		ST_IDLE       = 3'h1,
		ST_ERASE_FILL = 3'h2,
		ST_ERASE_WAIT = 3'h4
	} op_state_t;

	typedef struct packed {
		logic                    cs_s1;
		logic                    cs_s2;
		logic                    cs_d;
		logic                    sck_s1;
		logic                    sck_s2;
		logic                    sck_d;
		logic                    mosi_s1;
		logic                    mosi_s2;
		logic [5:0]              cnt;
		logic [31:0]             shift_in;
		logic [7:0]              op;
		logic [23:0]             addr;
		logic                    cmd_ok;
		logic                    active;
		logic                    miso_oe;
		logic [7:0]              out_shift;
		logic [7:0]              prefetch;
		logic                    fetch_pend;
		logic [1:0]              rsel;
		logic [7:0]              offset;
		logic                    rmw;
		logic                    prog_tail;
		logic                    prog_overflow;
		op_state_t               state;
		logic [7:0]              erase_idx;
		logic [31:0]             timer;
		logic                    wel_clr;
		logic                    prot;
		logic [`LOCK_COUNT-1:0]  locks;
	} core_state_t;

	typedef struct packed {
		logic [3:0] rd_ptr;
		logic [3:0] wr_ptr;
	} fifo_state_t;

endpackage

// ===== secreg_mem.sv
// byte memory holding the three security registers
// single port, read data come out of a register one cycle after the address
`timescale 1ns/1ps
`include "secreg_lock_map.svh"

module secreg_mem #(
	parameter int AW = `SECREG_ADDR_W,
	parameter int DW = `SECREG_DATA_W
) (
	input  wire logic          i_clock,
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_addr,
	input  wire logic [DW-1:0] i_wdata,
	output logic      [DW-1:0] o_rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// no reset on the array: contents are non-volatile by intent
	always_ff @(posedge i_clock) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata;
		end
		o_rdata <= mem[i_addr];
	end
endmodule

// ===== sync_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock; depth must be a power of two
`timescale 1ns/1ps
`include "secreg_lock_map.svh"

module sync_fifo
	import secreg_lock_pkg::*;
#(
	parameter int WIDTH = `SECREG_DATA_W,
	parameter int DEPTH = `PROG_FIFO_DEPTH
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int PW = $clog2(DEPTH);

	fifo_state_t      r;
	fifo_state_t      n;
	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic             push;
	logic             pop;

	// pointers carry one extra bit so full and empty differ
	always_comb begin
		n           = r;
		o_out_valid = (r.rd_ptr != r.wr_ptr);
		o_in_ready  = (r.rd_ptr[PW-1:0] != r.wr_ptr[PW-1:0]) || (r.rd_ptr[PW] == r.wr_ptr[PW]);
		push        = i_in_valid & o_in_ready;
		pop         = o_out_valid & i_out_ready;
		o_out_data  = store[r.rd_ptr[PW-1:0]];
		if (push) begin
			n.wr_ptr = r.wr_ptr + 4'h1;
		end
		if (pop) begin
			n.rd_ptr = r.rd_ptr + 4'h1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	always_ff @(posedge i_clock) begin
		if (push) begin
			store[r.wr_ptr[PW-1:0]] <= i_in_data;
		end
	end
endmodule

// ===== flash_secreg_lock.sv
// security register and individual block lock command handler of a serial flash
// assumes the link pins come straight from the host, sampled on i_clock;
// the status register, write latch and other busy sources live outside.
// limitation: sclk high and low phases each need three system clocks
`timescale 1ns/1ps
`include "secreg_lock_map.svh"

module flash_secreg_lock
	import secreg_lock_pkg::*;
#(
	parameter int unsigned SECTOR_ERASE_TIME_US = `SECTOR_ERASE_TIME_US
) (
	input  wire logic       i_clock,
	input  wire logic       i_rst_n,
	input  wire logic       i_spi_cs_n,
	input  wire logic       i_spi_sclk,
	input  wire logic       i_spi_mosi,
	output logic            o_spi_miso,
	output logic            o_spi_miso_oe,
	input  wire logic       i_write_latch_flag,
	output logic            o_write_latch_clear,
	input  wire logic [2:0] i_secreg_otp_lock_bits,
	input  wire logic       i_ext_busy,
	output logic            o_busy,
	input  wire logic       i_protect_scheme_select,
	input  wire logic       i_field_protect,
	input  wire logic [7:0] i_query_block,
	output logic            o_block_protected,
	output logic            o_program_overflow
);
	import secreg_lock_pkg::*;

	// erase length in system clocks; a whole microsecond count keeps the
	// timer a plain compare, at the cost of sub-microsecond resolution
	localparam int unsigned ERASE_CYCLES_INT = SECTOR_ERASE_TIME_US * `CLK_MHZ;
	localparam logic [31:0] ERASE_CYCLES = ERASE_CYCLES_INT[31:0];

	// whole block state in one register; synchronisers, command decode
	// and erase timer move together on every clock
	core_state_t r;
	core_state_t n;

	// decode and memory-port helpers, all combinational but mem_rdata, which comes from the memory's read register
	logic        sck_rise;
	logic        sck_fall;
	logic        cs_rise;
	logic        sel;
	logic        busy_own;
	logic        busy_any;
	logic        busy_seen;
	logic [31:0] word;
	logic        addr_ok;
	logic [1:0]  sel_idx;
	logic        otp_lk;
	logic        fetch_req;
	logic [5:0]  first_out;
	logic        mem_we;
	logic [9:0]  mem_addr;
	logic [7:0]  mem_wdata;
	logic [7:0]  mem_rdata;
	logic        fifo_push;
	logic        fifo_in_ready;
	logic [7:0]  fifo_in_data;
	logic        fifo_out_valid;
	logic        fifo_pop;
	logic [7:0]  fifo_out_data;

	// program bytes queue here; the drain side stalls while a read fetch holds the port
	// overflow needs a link faster than two clocks per byte; it is flagged, not stalled
	sync_fifo #(
		.WIDTH(`SECREG_DATA_W),
		.DEPTH(`PROG_FIFO_DEPTH)
	) u_prog_fifo (
		.i_clock     (i_clock),
		.i_rst_n     (i_rst_n),
		.i_in_valid  (fifo_push),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (fifo_in_data),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (fifo_pop),
		.o_out_data  (fifo_out_data)
	);

	secreg_mem #(
		.AW(`SECREG_ADDR_W),
		.DW(`SECREG_DATA_W)
	) u_mem (
		.i_clock (i_clock),
		.i_we    (mem_we),
		.i_addr  (mem_addr),
		.i_wdata (mem_wdata),
		.o_rdata (mem_rdata)
	);

	// link edges are found from the synchronised copies only
	// limitation: a sclk phase shorter than three clocks is missed
	assign sck_rise = r.sck_s2 & ~r.sck_d;
	assign sck_fall = ~r.sck_s2 & r.sck_d;
	assign cs_rise  = r.cs_s2 & ~r.cs_d;
	assign sel      = ~r.cs_s2;
	assign word     = {r.shift_in[30:0], r.mosi_s2};
	assign busy_own = (r.state != ST_IDLE) | fifo_out_valid | r.rmw | r.prog_tail;
	assign busy_any = busy_own | i_ext_busy;

	// status busy: the program drain runs while bytes still arrive, but the
	// host only sees a busy cycle once chip select is back high
	assign busy_seen = (r.state != ST_IDLE) | r.prog_tail | (~sel & (fifo_out_valid | r.rmw));

	// security register address decode
	// sel_idx is junk for a bad address; rsel latches it at bit 32 of every frame, other uses are gated by addr_ok
	always_comb begin
		addr_ok = (word[23:16] == `SECREG_HI_BYTE) && (word[11:8] == `SECREG_MID_NIBBLE) &&
			(word[15:12] >= `SECREG_SEL_FIRST) && (word[15:12] <= `SECREG_SEL_LAST);
		sel_idx = word[13:12] - 2'h1;
		otp_lk  = i_secreg_otp_lock_bits[sel_idx];
	end

	// whole command engine in one next-state process
	always_comb begin
		n            = r;
		fetch_req    = 1'b0;
		mem_we       = 1'b0;
		mem_wdata    = `ERASED_BYTE;
		fifo_push    = 1'b0;
		fifo_pop     = 1'b0;
		fifo_in_data = word[7:0];
		first_out    = (r.op == `OP_SECREG_READ) ? `CNT_DUMMY_DONE : `CNT_ADDR_DONE;

		// two-stage synchronisers on every link pin, then a third copy of chip select and clock for edge finding
		n.cs_s1   = i_spi_cs_n;
		n.cs_s2   = r.cs_s1;
		n.cs_d    = r.cs_s2;
		n.sck_s1  = i_spi_sclk;
		n.sck_s2  = r.sck_s1;
		n.sck_d   = r.sck_s2;
		n.mosi_s1 = i_spi_mosi;
		n.mosi_s2 = r.mosi_s1;
		n.wel_clr = 1'b0;
		// protection answer is one clock late, like any registered status bit
		n.prot    = i_protect_scheme_select ? r.locks[i_query_block] : i_field_protect;

		// the next byte is fetched a byte ahead, so the registered memory
		// read never holds up the link
		if (r.fetch_pend) begin
			n.prefetch   = mem_rdata;
			n.fetch_pend = 1'b0;
		end

		// rising edges: shift in opcode, address and program data
		// r.op holds the last frame's opcode until bit 32 of this one
		if (sel && sck_rise) begin
			n.shift_in = word;
			if (r.cnt == `CNT_READ_WRAP && r.op == `OP_SECREG_READ) begin
				n.cnt = `CNT_DUMMY_DONE;
			end else if (r.cnt == `CNT_BYTE_WRAP && r.op != `OP_SECREG_READ) begin
				n.cnt = `CNT_ADDR_DONE;
			end else begin
				n.cnt = r.cnt + 6'h01;
			end
			if (r.cnt == `CNT_ADDR_LAST) begin
				n.op     = word[31:24];
				n.addr   = word[23:0];
				n.rsel   = sel_idx;
				n.offset = word[7:0];
				case (word[31:24])
					`OP_SECREG_READ: begin
						n.active  = addr_ok & ~busy_any;
						fetch_req = addr_ok & ~busy_any;
					end
					// lock read has no address check and answers even while busy
					`OP_BLOCK_LOCK_READ: begin
						n.active   = 1'b1;
						n.prefetch = {7'h00, r.locks[word[23:16]]};
					end
					`OP_SECREG_PROGRAM, `OP_SECREG_ERASE: begin
						n.cmd_ok = addr_ok & i_write_latch_flag & ~busy_any & ~otp_lk;
					end
					`OP_BLOCK_LOCK, `OP_BLOCK_UNLOCK: begin
						n.cmd_ok = i_write_latch_flag & ~busy_any;
					end
					default: begin
						n.cmd_ok = 1'b0;
					end
				endcase
			end
			// a 33rd bit cancels erase, lock and unlock: the wrapping byte
			// counter alone cannot tell 32 bits from 40
			if (r.cnt == `CNT_ADDR_DONE && r.op != `OP_SECREG_PROGRAM) begin
				n.cmd_ok = 1'b0;
			end
			// each full data byte of an accepted program goes to the queue
			if (r.op == `OP_SECREG_PROGRAM && r.cmd_ok && r.cnt >= `CNT_BYTE_WRAP && r.cnt[2:0] == 3'h7) begin
				fifo_push = 1'b1;
				if (!fifo_in_ready) begin
					n.prog_overflow = 1'b1;
				end
			end
		end

		// falling edges: shift out read data, msb first
		// data change half a period ahead of the host's sampling edge
		if (sel && sck_fall && r.active && r.cnt >= first_out) begin
			if (r.cnt[2:0] == 3'h0) begin
				n.out_shift = r.prefetch;
				n.miso_oe   = 1'b1;
				if (r.op == `OP_SECREG_READ) begin
					n.offset  = r.offset + 8'h01;
					fetch_req = 1'b1;
				end
			end else begin
				n.out_shift = {r.out_shift[6:0], 1'b0};
			end
		end

		// chip select high ends the frame; erase, lock and unlock execute only at bit 32
		// a cut frame leaves nothing half done: count, drive and acceptance all drop
		if (!sel) begin
			n.cnt     = 6'h00;
			n.active  = 1'b0;
			n.miso_oe = 1'b0;
			n.cmd_ok  = 1'b0;
		end
		if (cs_rise) begin
			n.prog_overflow = 1'b0;
			if (r.op == `OP_SECREG_PROGRAM && r.cmd_ok) begin
				n.prog_tail = 1'b1;
			end
			if (r.cnt == `CNT_ADDR_DONE && r.cmd_ok) begin
				case (r.op)
					`OP_SECREG_ERASE: begin
						n.state     = ST_ERASE_FILL;
						n.erase_idx = 8'h00;
					end
					// lock and unlock leave the write latch set
					`OP_BLOCK_LOCK: begin
						n.locks[r.addr[23:16]] = 1'b1;
					end
					`OP_BLOCK_UNLOCK: begin
						n.locks[r.addr[23:16]] = 1'b0;
					end
					default: begin
						n.cmd_ok = 1'b0;
					end
				endcase
			end
		end

		// memory port: read fetch first, erase fill, then program read-modify-write
		// the new select is used: the first read fetch falls in the cycle
		// that latches the register select
		mem_addr = {n.rsel, n.offset};
		if (fetch_req) begin
			n.fetch_pend = 1'b1;
		end else begin
			case (r.state)
				// one erased byte per clock, then the timed wait; reads are refused meanwhile
				ST_ERASE_FILL: begin
					mem_we   = 1'b1;
					mem_addr = {r.rsel, r.erase_idx};
					n.erase_idx = r.erase_idx + 8'h01;
					if (r.erase_idx == `LAST_OFFSET) begin
						n.state = ST_ERASE_WAIT;
						n.timer = 32'h0000_0000;
					end
				end
				// latch clear pulses in the very cycle busy drops
				ST_ERASE_WAIT: begin
					n.timer = r.timer + 32'h0000_0001;
					if (r.timer >= ERASE_CYCLES - 32'h0000_0001) begin
						n.state   = ST_IDLE;
						n.wel_clr = 1'b1;
					end
				end
				ST_IDLE: begin
					// two clocks per byte: fetch the old value, then write old and new
					if (r.rmw) begin
						mem_we    = 1'b1;
						mem_addr  = {r.rsel, r.offset};
						mem_wdata = mem_rdata & fifo_out_data; // only clears erased bits
						fifo_pop  = 1'b1;
						n.offset  = r.offset + 8'h01; // wraps in the register
						n.rmw     = 1'b0;
					end else if (fifo_out_valid) begin
						mem_addr = {r.rsel, r.offset};
						n.rmw    = 1'b1;
					end else if (r.prog_tail && !fifo_push) begin
						// latch clear only once the last queued byte is in the array
						n.prog_tail = 1'b0;
						n.wel_clr   = 1'b1;
					end
				end
				default: begin
					n.state = ST_IDLE;
				end
			endcase
		end
	end

	// async reset: all lock bits come up set
	// chip select copies reset high so no false frame start follows reset
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r        <= '0;
			r.cs_s1  <= 1'b1;
			r.cs_s2  <= 1'b1;
			r.cs_d   <= 1'b1;
			r.state  <= ST_IDLE;
			r.locks  <= {`LOCK_COUNT{`LOCK_RESET}};
			r.prot   <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// every output but busy comes straight from a register
	assign o_spi_miso          = r.out_shift[7];
	assign o_spi_miso_oe       = r.miso_oe;
	assign o_write_latch_clear = r.wel_clr;
	assign o_busy              = busy_seen;
	assign o_block_protected   = r.prot;
	assign o_program_overflow  = r.prog_overflow;
endmodule

// ===== flash_secreg_lock_assertions.sv
// concurrent checks on the ports of the security register and lock handler
// assumes one clock domain and a bind onto flash_secreg_lock
`timescale 1ns/1ps

module flash_secreg_lock_assertions (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_spi_cs_n,
	input wire logic o_spi_miso_oe,
	input wire logic i_write_latch_flag,
	input wire logic o_write_latch_clear,
	input wire logic o_busy,
	input wire logic i_protect_scheme_select,
	input wire logic i_field_protect,
	input wire logic o_block_protected,
	input wire logic o_program_overflow
);
	logic up_reg;

	// registered outputs still show reset values one edge after release
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) up_reg <= 1'h0;
		else up_reg <= 1'h1;
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	field_prot_a: assert property (up_reg && !$past(i_protect_scheme_select) |->
		o_block_protected == $past(i_field_protect)) else $error("field protect not followed");
	clear_pulse_a: assert property (o_write_latch_clear |=> !o_write_latch_clear)
		else $error("latch clear longer than one cycle");
	clear_idle_a: assert property (o_write_latch_clear |-> !o_busy)
		else $error("latch clear while busy");
	oe_cs_a: assert property (i_spi_cs_n [*6] |-> !o_spi_miso_oe)
		else $error("data out driven with chip select high");
	oe_start_a: assert property ($rose(o_spi_miso_oe) |-> !i_spi_cs_n)
		else $error("data out started outside a frame");
	busy_start_a: assert property ($rose(o_busy) |-> i_spi_cs_n)
		else $error("busy rose inside a frame");
	busy_latch_a: assert property ($rose(o_busy) |-> i_write_latch_flag)
		else $error("busy without write latch");
	busy_read_a: assert property (o_busy |-> !o_spi_miso_oe)
		else $error("read served while busy");
	ovf_clear_a: assert property (i_spi_cs_n [*5] |-> !o_program_overflow)
		else $error("overflow flag not cleared");

	cover property ($fell(o_busy));
	cover property ($rose(o_spi_miso_oe));
	cover property (o_write_latch_clear);
endmodule

bind flash_secreg_lock flash_secreg_lock_assertions u_chk (
	.i_clock(i_clock), .i_rst_n(i_rst_n), .i_spi_cs_n(i_spi_cs_n), .o_spi_miso_oe(o_spi_miso_oe),
	.i_write_latch_flag(i_write_latch_flag), .o_write_latch_clear(o_write_latch_clear), .o_busy(o_busy),
	.i_protect_scheme_select(i_protect_scheme_select), .i_field_protect(i_field_protect),
	.o_block_protected(o_block_protected), .o_program_overflow(o_program_overflow)
);

// ===== spi_host_model.sv
// link host model: chip select, serial clock and data in, mode 0, 80 ns clock
// assumes the device samples these pins with its own unrelated clock
`timescale 1ns/1ps

module spi_host_model (
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_mosi,
	input  wire logic i_miso
);
	logic [7:0] rx;
	logic [7:0] rxq [$];

	// clock parked low between frames
	initial begin
		o_cs_n = 1'h1;
		o_sclk = 1'h0;
		o_mosi = 1'h0;
	end

	// msb first, data set while the clock is low, read data taken on the rise
	task automatic xbyte(input logic [7:0] tx);
		for (int i = 7; i >= 0; i--) begin
			o_mosi = tx[i];
			#40 o_sclk = 1'h1;
			rx = {rx[6:0], i_miso};
			#40 o_sclk = 1'h0;
		end
	endtask

	// one command per frame; chip select held low through every data byte
	task automatic frame(input logic [7:0] op, input logic [23:0] a, input int n, input logic [7:0] d);
		rxq.delete();
		o_cs_n = 1'h0;
		#40 xbyte(op);
		xbyte(a[23:16]);
		xbyte(a[15:8]);
		xbyte(a[7:0]);
		for (int k = 0; k < n; k++) begin
			xbyte(d + 8'(k));
			rxq.push_back(rx);
		end
		#40 o_cs_n = 1'h1;
		o_mosi = ~o_mosi; // released line must not keep its last value
		#120;
	endtask
endmodule

// ===== flash_secreg_lock_bench.sv
// self-checking bench for the security register and block lock handler
// assumes the host model drives the link and the bench plays the status logic
`timescale 1ns/1ps
`include "secreg_lock_map.svh"
`define CHECK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end

module flash_secreg_lock_bench;
	logic       i_clock;
	logic       i_rst_n;
	logic       cs_n, sclk, mosi, miso, oe, write_latch_flag, clr, ext_busy, busy, pss, fprot, prot, ovf, oe_seen;
	logic [2:0] otp;
	logic [7:0] qblk;
	int         mismatches, checks, clears, cyc;

	spi_host_model u_host (.o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi), .i_miso(miso));
	flash_secreg_lock #(.SECTOR_ERASE_TIME_US(1)) u_dut (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_spi_cs_n(cs_n), .i_spi_sclk(sclk), .i_spi_mosi(mosi),
		.o_spi_miso(miso), .o_spi_miso_oe(oe), .i_write_latch_flag(write_latch_flag), .o_write_latch_clear(clr),
		.i_secreg_otp_lock_bits(otp), .i_ext_busy(ext_busy), .o_busy(busy), .i_protect_scheme_select(pss),
		.i_field_protect(fprot), .i_query_block(qblk), .o_block_protected(prot), .o_program_overflow(ovf)
	);

	initial begin
		i_clock = 1'h0;
		forever #4 i_clock = ~i_clock;
	end

	// counts latch clears, notes any data drive, cuts a hang short
	always @(posedge i_clock) begin
		cyc++;
		if (clr === 1'h1) clears++;
		if (oe === 1'h1) oe_seen = 1'h1;
		if (cyc == 60000) begin
			mismatches++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask

	task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n, input logic [7:0] d);
		tick(1);
		u_host.frame(op, a, n, d);
		tick(1);
	endtask

	task automatic wait_busy(input logic lvl, input int lim);
		for (int i = 0; i < lim && busy !== lvl; i++) tick(1);
	endtask

	task automatic t_reset();
		for (int b = 0; b < 256; b++) begin
			qblk = 8'(b);
			tick(2);
			`CHECK("lock after reset", 1'h1, prot)
		end
		pss = 1'h0;
		fprot = 1'h0;
		tick(2);
		`CHECK("field protect", 1'h0, prot)
		pss = 1'h1;
	endtask

	task automatic t_lock();
		qblk = 8'h05;
		cmd(`OP_BLOCK_UNLOCK, 24'h050000, 0, 8'h00);
		`CHECK("unlock without latch", 1'h1, prot)
		write_latch_flag = 1'h1;
		cmd(`OP_BLOCK_UNLOCK, 24'h050000, 0, 8'h00);
		`CHECK("unlock", 1'h0, prot)
		cmd(`OP_BLOCK_LOCK_READ, 24'h050000, 2, 8'h00);
		`CHECK("lock read open", 8'h00, u_host.rxq[0])
		qblk = 8'h06;
		tick(2);
		`CHECK("neighbour lock", 1'h1, prot)
		cmd(`OP_BLOCK_LOCK, 24'h050000, 0, 8'h00);
		cmd(`OP_BLOCK_LOCK_READ, 24'h050000, 1, 8'h00);
		`CHECK("lock read locked", 8'h01, u_host.rxq[0])
	endtask

	task automatic t_erase();
		int c0;
		cmd(`OP_SECREG_ERASE, 24'h002000, 1, 8'h00);
		`CHECK("erase long frame", 1'h0, busy)
		c0 = clears;
		cmd(`OP_SECREG_ERASE, 24'h002000, 0, 8'h00);
		tick(340);
		`CHECK("erase still busy", 1'h1, busy)
		wait_busy(1'h0, 200);
		`CHECK("erase done", 1'h0, busy)
		tick(1);
		`CHECK("erase latch clear", c0 + 1, clears)
	endtask

	task automatic t_prog();
		int c0;
		logic [7:0] exp [4] = '{8'hA0, 8'hA1, 8'hA2, 8'hFF};
		c0 = clears;
		cmd(`OP_SECREG_PROGRAM, 24'h0020FE, 3, 8'hA0);
		wait_busy(1'h0, 100);
		`CHECK("program latch clear", c0 + 1, clears)
		`CHECK("no overflow", 1'h0, ovf)
		write_latch_flag = 1'h0;
		cmd(`OP_SECREG_PROGRAM, 24'h002001, 1, 8'h00);
		write_latch_flag = 1'h1;
		cmd(`OP_SECREG_READ, 24'h0020FE, 5, 8'h00);
		for (int k = 0; k < 4; k++) `CHECK("read data", exp[k], u_host.rxq[k + 1])
	endtask

	task automatic t_refuse();
		oe_seen = 1'h0;
		cmd(`OP_SECREG_READ, 24'h004000, 2, 8'h00);
		`CHECK("read bad address", 1'h0, oe_seen)
		ext_busy = 1'h1;
		cmd(`OP_SECREG_READ, 24'h002000, 2, 8'h00);
		`CHECK("read while busy", 1'h0, oe_seen)
		ext_busy = 1'h0;
		otp = 3'h2;
		cmd(`OP_SECREG_ERASE, 24'h002000, 0, 8'h00);
		`CHECK("erase locked register", 1'h0, busy)
		cmd(`OP_SECREG_PROGRAM, 24'h002001, 1, 8'h00);
		cmd(`OP_SECREG_READ, 24'h0020FF, 4, 8'h00);
		`CHECK("locked data kept", 8'hA1, u_host.rxq[1])
		`CHECK("locked program refused", 8'hFF, u_host.rxq[3])
	endtask

	initial begin
		i_rst_n = 1'h0;
		write_latch_flag = 1'h0;
		otp = 3'h0;
		ext_busy = 1'h0;
		pss = 1'h1;
		fprot = 1'h1;
		qblk = 8'h00;
		oe_seen = 1'h0;
		tick(10);
		i_rst_n = 1'h1;
		tick(4);
		t_reset();
		t_lock();
		t_erase();
		t_prog();
		t_refuse();
		stop_test();
	end
endmodule
